// [common/tpg_pkg.sv]
// Shared constants and types for the three-port general purpose I/O block.
// Assumes the core reaches the block through its special function
// register space with an 8-bit address and 8-bit data.

`default_nettype none

package tpg_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int PORT_W   = 8;
    localparam int PIN_W    = 24;            // Port 0, port 1, port 3
    localparam int PIN_USED = 22;            // Bonded pins
    localparam int PORT0_LSB = 0;
    localparam int PORT1_LSB = 8;
    localparam int PORT3_LSB = 16;

    // Port 1 bits 2 and 5 have no pad
    localparam logic [PORT_W-1:0] PORT1_PRESENT = 8'hdb;
    localparam logic [PIN_W-1:0]  PIN_PRESENT  = {8'hff, 8'hdb, 8'hff};
    // Port 3 bits 3..2 are the external interrupt lines
    localparam logic [PIN_W-1:0]  PIN_IRQ_CAP  = {8'hf3, 8'hdb, 8'hff};
    localparam int                EXT_INT_LSB  = 18;
    localparam int                EXT_INT_W    = 2;

    // ------------------------------------------------------------
    // Register offsets in the special function register space
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_PORT0_DATA = 8'h80;
    localparam logic [7:0] ADDR_PORT1_DATA = 8'h90;
    localparam logic [7:0] ADDR_PORT3_DATA = 8'hb0;
    localparam logic [7:0] ADDR_PORT0_DIR  = 8'hb1;
    localparam logic [7:0] ADDR_PORT1_DIR  = 8'hb2;
    localparam logic [7:0] ADDR_PORT3_DIR  = 8'hb4;
    localparam logic [7:0] ADDR_PORT0_GATE = 8'hb9;
    localparam logic [7:0] ADDR_PORT1_GATE = 8'hba;
    localparam logic [7:0] ADDR_PORT3_GATE = 8'hbc;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [PIN_W-1:0]  RST_DATA  = 24'h000000;
    localparam logic [PIN_W-1:0]  RST_DIR   = 24'hffffff;
    localparam logic [PIN_W-1:0]  RST_GATE  = 24'hffffff;
    localparam logic [PORT_W-1:0] RST_RDATA = 8'h00;
    localparam logic              RST_SYNC  = 1'b1;   // Pulled-up idle

    // Port pin interrupt vectors
    localparam logic [7:0] VEC_NORMAL    = 8'h83;
    localparam logic [7:0] VEC_POWERDOWN = 8'h7b;

    // Pad control bundle for one pin
    typedef struct packed {
        logic out;        // Value driven when enabled
        logic oe;         // High while the pad is driven
        logic pull_up;
        logic pull_down;
        logic strength;   // 1: high drive
    } tpg_pad_drive_type;

endpackage

`default_nettype wire

// [logic/tpg_pad_cell.sv]
// One general purpose pad: input synchroniser, input gate and drive
// control. Assumes pad_in is asynchronous to clk.

`timescale 1ns/1ps
`default_nettype none

module tpg_pad_cell
    import tpg_pkg::*;
#(
    parameter logic PRESENT = 1'b1
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // Pad side
    input  wire logic        pad_in,
    output tpg_pad_drive_type drive,
    // Control side
    input  wire logic        latch,
    input  wire logic        drive_disable_n,
    input  wire logic        gate,
    input  wire logic        pull_enable,
    input  wire logic        pull_select,
    input  wire logic        drive_strength_sel,
    output logic             level
);

    logic              s1;
    logic              s2;
    logic              s3;
    logic              stable;
    logic              next_stable;
    logic              next_level;
    tpg_pad_drive_type next_drive;

    // ------------------------------------------------------------
    // Input path
    // ------------------------------------------------------------
    // A change is accepted only once stages two and three agree
    always_comb begin
        next_stable = (s2 == s3) ? s3 : stable;
        next_level  = PRESENT & gate & next_stable;         // [RL12]
    end

    // ------------------------------------------------------------
    // Pad truth table
    // ------------------------------------------------------------
    always_comb begin
        next_drive.out       = PRESENT & latch;
        next_drive.oe        = PRESENT & ~drive_disable_n;   // [RL3]
        next_drive.pull_up   = PRESENT & drive_disable_n
                               & pull_enable & pull_select;  // [RL3]
        next_drive.pull_down = PRESENT & drive_disable_n
                               & pull_enable & ~pull_select; // [RL3]
        next_drive.strength  = PRESENT & drive_strength_sel;
    end

    // Registers; reset leaves an input with pull-up
    always_ff @(posedge clk) begin
        if (!nrst) begin
            s1                <= RST_SYNC;
            s2                <= RST_SYNC;
            s3                <= RST_SYNC;
            stable            <= RST_SYNC;
            level             <= 1'b0;
            drive.out         <= 1'b0;
            drive.oe          <= 1'b0;                       // [RL2]
            drive.pull_up     <= PRESENT;                    // [RL2]
            drive.pull_down   <= 1'b0;
            drive.strength    <= 1'b0;
        end else begin
            s1                <= pad_in;
            s2                <= s1;
            s3                <= s2;
            stable            <= next_stable;
            level             <= next_level;
            drive             <= next_drive;
        end
    end

endmodule

`default_nettype wire

// [logic/tpg_gpio.sv]
// Three-port general purpose I/O block: data latches, direction and
// input gate registers on the special function register bus, pads,
// and the interrupt source levels for the interrupt controller.
// Assumes pull and drive strength settings arrive from an always-on
// register block on the same clock, and a power manager gives mode.
//
// Functional notes
// [RL1] 22 pins, ports 0/1/3, per-bit control
// [RL2] After reset: inputs with pull-up
// [RL3] Pad: drive, float, pull-down or pull-up
// [RL4] Data read returns present pin state
// [RL5] Data write sets output bits
// [RL6] Direction bit 1 input, reset all ones
// [RL7] Input gate 1 passes, reset ones
// [RL8] Port 1 bits 2, 5 reserved
// [RL9] Pin interrupts except port 3 bits 3:2
// [RL10] Port 3 bits 3:2 external, wake capable
// [RL11] Vector differs: normal or power-down
// [RL12] Gated input reads as zero

`timescale 1ns/1ps
`default_nettype none

module tpg_gpio
    import tpg_pkg::*;
(
    // Clock and reset
    input  wire logic                 CLK,
    input  wire logic                 NRST,
    // Special function register bus
    input  wire logic [7:0]           SFR_ADDR,
    input  wire logic                 SFR_WR,
    input  wire logic                 SFR_RD,
    input  wire logic [PORT_W-1:0]    SFR_WDATA,
    output logic      [PORT_W-1:0]    SFR_RDATA,
    // Pull and strength settings from the always-on block
    input  wire logic [PIN_W-1:0]     PULL_ENABLE,
    input  wire logic [PIN_W-1:0]     PULL_SELECT,
    input  wire logic [PIN_W-1:0]     DRIVE_STRENGTH_SEL,
    // Pads
    input  wire logic [PIN_W-1:0]     PAD_IN,
    output logic      [PIN_W-1:0]     PAD_OUT,
    output logic      [PIN_W-1:0]     PAD_OE,
    output logic      [PIN_W-1:0]     PAD_PULL_UP,
    output logic      [PIN_W-1:0]     PAD_PULL_DOWN,
    output logic      [PIN_W-1:0]     PAD_STRENGTH,
    // Interrupt sources
    input  wire logic                 POWER_DOWN,
    output logic      [PIN_W-1:0]     PIN_IRQ_LEVEL,
    output logic      [EXT_INT_W-1:0] EXT_INT_LEVEL,
    output logic      [7:0]           IRQ_VECTOR
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic              [PIN_W-1:0]  data_latch;
    logic              [PIN_W-1:0]  drive_disable_n;
    logic              [PIN_W-1:0]  input_gate;
    logic              [PIN_W-1:0]  next_data_latch;
    logic              [PIN_W-1:0]  next_drive_disable_n;
    logic              [PIN_W-1:0]  next_input_gate;
    logic              [PORT_W-1:0] next_rdata;
    logic              [PIN_W-1:0]  pin_level;
    tpg_pad_drive_type              pad_drive [PIN_W];
    logic              [PIN_W-1:0]  next_irq_level;
    logic              [EXT_INT_W-1:0] next_ext_level;
    logic              [7:0]        next_vector;

    // Place a written byte into one port of a 24-bit vector,
    // keeping missing pads at zero
    function automatic logic [PIN_W-1:0] put_port(
        input logic [PIN_W-1:0]  vec,
        input int                lsb,
        input logic [PORT_W-1:0] val
    );
        logic [PIN_W-1:0] res;
        res = vec;
        res[lsb +: PORT_W] = val;
        return res & PIN_PRESENT;                           // [RL8]
    endfunction

    // Read one port of a vector; reserved bits read as zero
    function automatic logic [PORT_W-1:0] get_port(
        input logic [PIN_W-1:0] vec,
        input int               lsb
    );
        logic [PIN_W-1:0] masked;
        masked = vec & PIN_PRESENT;                         // [RL8]
        return masked[lsb +: PORT_W];
    endfunction

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    // Direction and gate reset to ones so pins come up as inputs
    always_comb begin
        next_data_latch      = data_latch;
        next_drive_disable_n = drive_disable_n;
        next_input_gate      = input_gate;
        if (SFR_WR) begin
            case (SFR_ADDR)
                ADDR_PORT0_DATA: next_data_latch =
                    put_port(data_latch, PORT0_LSB, SFR_WDATA);     // [RL5]
                ADDR_PORT1_DATA: next_data_latch =
                    put_port(data_latch, PORT1_LSB, SFR_WDATA);     // [RL5]
                ADDR_PORT3_DATA: next_data_latch =
                    put_port(data_latch, PORT3_LSB, SFR_WDATA);     // [RL5]
                ADDR_PORT0_DIR:  next_drive_disable_n =
                    put_port(drive_disable_n, PORT0_LSB, SFR_WDATA); // [RL6]
                ADDR_PORT1_DIR:  next_drive_disable_n =
                    put_port(drive_disable_n, PORT1_LSB, SFR_WDATA); // [RL6]
                ADDR_PORT3_DIR:  next_drive_disable_n =
                    put_port(drive_disable_n, PORT3_LSB, SFR_WDATA); // [RL6]
                ADDR_PORT0_GATE: next_input_gate =
                    put_port(input_gate, PORT0_LSB, SFR_WDATA);     // [RL7]
                ADDR_PORT1_GATE: next_input_gate =
                    put_port(input_gate, PORT1_LSB, SFR_WDATA);     // [RL7]
                ADDR_PORT3_GATE: next_input_gate =
                    put_port(input_gate, PORT3_LSB, SFR_WDATA);     // [RL7]
                default: ;   // Other addresses belong to other blocks
            endcase
        end
    end

    // ------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------
    // Data reads show the synchronised pin, not the latch, so a
    // read-modify-write on a pin held by a load can flip its latch
    always_comb begin
        next_rdata = SFR_RDATA;
        if (SFR_RD) begin
            case (SFR_ADDR)
                ADDR_PORT0_DATA: next_rdata =
                    get_port(pin_level, PORT0_LSB);                 // [RL4]
                ADDR_PORT1_DATA: next_rdata =
                    get_port(pin_level, PORT1_LSB);                 // [RL4]
                ADDR_PORT3_DATA: next_rdata =
                    get_port(pin_level, PORT3_LSB);                 // [RL4]
                ADDR_PORT0_DIR:  next_rdata =
                    get_port(drive_disable_n, PORT0_LSB);
                ADDR_PORT1_DIR:  next_rdata =
                    get_port(drive_disable_n, PORT1_LSB);
                ADDR_PORT3_DIR:  next_rdata =
                    get_port(drive_disable_n, PORT3_LSB);
                ADDR_PORT0_GATE: next_rdata =
                    get_port(input_gate, PORT0_LSB);
                ADDR_PORT1_GATE: next_rdata =
                    get_port(input_gate, PORT1_LSB);
                ADDR_PORT3_GATE: next_rdata =
                    get_port(input_gate, PORT3_LSB);
                default:      next_rdata = RST_RDATA;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Interrupt sources
    // ------------------------------------------------------------
    // Pin interrupts only in normal mode; the external lines stay
    // live in power-down so they can wake the core
    always_comb begin
        next_irq_level = POWER_DOWN ? '0
                         : (pin_level & PIN_IRQ_CAP);       // [RL9]
        next_ext_level = pin_level[EXT_INT_LSB +: EXT_INT_W]; // [RL10]
        next_vector    = POWER_DOWN ? VEC_POWERDOWN
                         : VEC_NORMAL;                      // [RL11]
    end

    // Register stage for all of the above
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            data_latch      <= RST_DATA;
            drive_disable_n <= RST_DIR & PIN_PRESENT;       // [RL6]
            input_gate      <= RST_GATE & PIN_PRESENT;      // [RL7]
            SFR_RDATA       <= RST_RDATA;
            PIN_IRQ_LEVEL   <= '0;
            EXT_INT_LEVEL   <= '0;
            IRQ_VECTOR      <= VEC_NORMAL;
        end else begin
            data_latch      <= next_data_latch;
            drive_disable_n <= next_drive_disable_n;
            input_gate      <= next_input_gate;
            SFR_RDATA       <= next_rdata;
            PIN_IRQ_LEVEL   <= next_irq_level;
            EXT_INT_LEVEL   <= next_ext_level;
            IRQ_VECTOR      <= next_vector;
        end
    end

    // ------------------------------------------------------------
    // Pads
    // ------------------------------------------------------------
    // One cell per bit position; absent pads are built but held off
    for (genvar i = 0; i < PIN_W; i++) begin : g_pad
        tpg_pad_cell #(
            .PRESENT (PIN_PRESENT[i])                       // [RL1]
        ) u_cell (
            .clk                (CLK),
            .nrst               (NRST),
            .pad_in             (PAD_IN[i]),
            .drive              (pad_drive[i]),
            .latch              (data_latch[i]),
            .drive_disable_n    (drive_disable_n[i]),
            .gate               (input_gate[i]),
            .pull_enable        (PULL_ENABLE[i]),
            .pull_select        (PULL_SELECT[i]),
            .drive_strength_sel (DRIVE_STRENGTH_SEL[i]),
            .level              (pin_level[i])
        );
        // Cell outputs are flip-flops, unpacked here
        assign PAD_OUT[i]       = pad_drive[i].out;
        assign PAD_OE[i]        = pad_drive[i].oe;
        assign PAD_PULL_UP[i]   = pad_drive[i].pull_up;
        assign PAD_PULL_DOWN[i] = pad_drive[i].pull_down;
        assign PAD_STRENGTH[i]  = pad_drive[i].strength;
    end

endmodule

`default_nettype wire

// [verification/tpg_gpio_checker.sv]
// Port assertions for the three-port I/O block.
// Assumes it is bound to tpg_gpio and sees the ports by name.
`timescale 1ns/1ps
`default_nettype none
module tpg_gpio_checker
    import tpg_pkg::*;
(
    // Clock, reset and register bus
    input wire logic                 CLK,
    input wire logic                 NRST,
    input wire logic [7:0]           SFR_ADDR,
    input wire logic                 SFR_WR,
    input wire logic                 SFR_RD,
    input wire logic [PORT_W-1:0]    SFR_WDATA,
    input wire logic [PORT_W-1:0]    SFR_RDATA,
    // Pads and interrupt sources
    input wire logic [PIN_W-1:0]     PAD_OUT,
    input wire logic [PIN_W-1:0]     PAD_OE,
    input wire logic [PIN_W-1:0]     PAD_PULL_UP,
    input wire logic [PIN_W-1:0]     PAD_PULL_DOWN,
    input wire logic [PIN_W-1:0]     PAD_STRENGTH,
    input wire logic                 POWER_DOWN,
    input wire logic [PIN_W-1:0]     PIN_IRQ_LEVEL,
    input wire logic [EXT_INT_W-1:0] EXT_INT_LEVEL,
    input wire logic [7:0]           IRQ_VECTOR
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    logic mapped;
    // Decoded register space; anything else must read as zero
    assign mapped = SFR_ADDR inside {ADDR_PORT0_DATA, ADDR_PORT1_DATA,
        ADDR_PORT3_DATA, ADDR_PORT0_DIR, ADDR_PORT1_DIR, ADDR_PORT3_DIR,
        ADDR_PORT0_GATE, ADDR_PORT1_GATE, ADDR_PORT3_GATE};
    // Reset has no disable of its own, or it could never be seen
    reset_state_a: assert property (disable iff (1'b0)
        !NRST |=> PAD_OE == '0 && PAD_PULL_UP == PIN_PRESENT)
        else $error("pads not inputs with pull-up after reset");
    dir_write_a: assert property (SFR_WR &&
        SFR_ADDR == ADDR_PORT0_DIR
        |-> ##2 PAD_OE[7:0] == ~$past(SFR_WDATA, 2))
        else $error("port 0 drive does not follow direction write");
    data_write_a: assert property (SFR_WR &&
        SFR_ADDR == ADDR_PORT0_DATA
        |-> ##2 PAD_OUT[7:0] == $past(SFR_WDATA, 2))
        else $error("port 0 output does not follow data write");
    oe_pull_a: assert property ((PAD_OE & (PAD_PULL_UP |
        PAD_PULL_DOWN)) == '0 && (PAD_PULL_UP & PAD_PULL_DOWN) == '0)
        else $error("pull active on a driven pin or both pulls on");
    reserved_pin_a: assert property (((PAD_OE | PAD_OUT | PAD_STRENGTH |
        PAD_PULL_UP | PAD_PULL_DOWN) & ~PIN_PRESENT) == '0)
        else $error("output seen on a pin that has no pad");
    irq_mask_a: assert property (
        (PIN_IRQ_LEVEL & ~PIN_IRQ_CAP) == '0)
        else $error("pin interrupt level on an excluded pin");
    pd_irq_a: assert property ($past(NRST) && $past(POWER_DOWN)
        |-> PIN_IRQ_LEVEL == '0)
        else $error("pin interrupt level during power-down");
    irq_vector_a: assert property ($past(NRST) |-> IRQ_VECTOR ==
        ($past(POWER_DOWN) ? VEC_POWERDOWN : VEC_NORMAL))
        else $error("interrupt vector does not match the mode");
    unmapped_read_a: assert property (
        SFR_RD && !mapped |=> SFR_RDATA == '0)
        else $error("unmapped read gave nonzero data");
    cover property (SFR_WR && SFR_ADDR == ADDR_PORT0_DIR);
    cover property (POWER_DOWN && EXT_INT_LEVEL != '0);
    cover property (SFR_RD && !mapped);
endmodule
`default_nettype wire

// [verification/tpg_pad_model.sv]
// Far side of the pads: resolves each pin from the block's drive,
// its pulls and an external driver that the bench controls.
`timescale 1ns/1ps
`default_nettype none
module tpg_pad_model
    import tpg_pkg::*;
(
    // Clock
    input  wire logic             clk,
    // Block side
    input  wire logic [PIN_W-1:0] pad_out,
    input  wire logic [PIN_W-1:0] pad_oe,
    input  wire logic [PIN_W-1:0] pull_up,
    input  wire logic [PIN_W-1:0] pull_down,
    // External driver
    input  wire logic [PIN_W-1:0] ext_en,
    input  wire logic [PIN_W-1:0] ext_val,
    output logic      [PIN_W-1:0] pad_in
);
    logic flt;
    // Floating pins wander, so a stale value never passes as settled
    always_ff @(posedge clk) begin
        flt <= (flt === 1'b1) ? 1'b0 : 1'b1;
    end
    // Block drive wins, then the device, then a pull, else float
    always_comb begin
        for (int i = 0; i < PIN_W; i++) begin
            pad_in[i] = pad_oe[i] ? pad_out[i] :
                ext_en[i] ? ext_val[i] : pull_up[i] ? 1'b1 :
                pull_down[i] ? 1'b0 : flt;
        end
    end
endmodule
`default_nettype wire

// [verification/tpg_gpio_test.sv]
// Self-checking bench for the three-port I/O block and pad model.
// Assumes package, block, model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tpg_gpio_test
    import tpg_pkg::*;
;
    logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, pd = 1'b0;
    logic [7:0] addr = '0, wdata = '0, rdata, vec, v;
    logic [PIN_W-1:0] pull_enable = '1, pull_select = '1;
    logic [PIN_W-1:0] drive_strength_sel = 24'h00ff00;
    logic [PIN_W-1:0] ext_en = '0, ext_val = '0;
    logic [PIN_W-1:0] pad_in, pad_out, pad_oe, pu, pdn, pst, irq;
    logic [1:0] ext_int;
    int errors = 0, cmp_count = 0, cycles = 0;
    // Rows: address, written value, value read back
    logic [7:0] ra [9] = '{8'hb1, 8'hb2, 8'hb4, 8'hb4, 8'hb1, 8'hb9,
                           8'hba, 8'hb9, 8'h81};
    logic [7:0] rw [9] = '{8'h5a, 8'hff, 8'h0f, 8'hff, 8'hff, 8'h3c,
                           8'hff, 8'hff, 8'h55};
    logic [7:0] re [9] = '{8'h5a, 8'hdb, 8'h0f, 8'hff, 8'hff, 8'h3c,
                           8'hdb, 8'hff, 8'h00};
    logic [7:0] ga [6] = '{8'hb1, 8'hb2, 8'hb4, 8'hb9, 8'hba, 8'hbc};
    logic [7:0] ge [6] = '{8'hff, 8'hdb, 8'hff, 8'hff, 8'hdb, 8'hff};
    always #4 clk = ~clk;
    tpg_gpio u_tpg_gpio (.CLK(clk), .NRST(nrst), .SFR_ADDR(addr),
        .SFR_WR(wr), .SFR_RD(rd), .SFR_WDATA(wdata), .SFR_RDATA(rdata),
        .PULL_ENABLE(pull_enable), .PULL_SELECT(pull_select),
        .DRIVE_STRENGTH_SEL(drive_strength_sel),
        .PAD_IN(pad_in), .PAD_OUT(pad_out), .PAD_OE(pad_oe),
        .PAD_PULL_UP(pu), .PAD_PULL_DOWN(pdn), .PAD_STRENGTH(pst),
        .POWER_DOWN(pd), .PIN_IRQ_LEVEL(irq), .EXT_INT_LEVEL(ext_int),
        .IRQ_VECTOR(vec));
    tpg_pad_model u_tpg_pad_model (.clk(clk), .pad_out(pad_out),
        .pad_oe(pad_oe), .pull_up(pu), .pull_down(pdn), .ext_en(ext_en),
        .ext_val(ext_val), .pad_in(pad_in));
    // Inputs always move 1 ns after the rising edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        cyc(1);
        addr = a;
        wdata = d;
        wr = 1'b1;
        cyc(1);
        wr = 1'b0;
    endtask
    // Data is taken one edge late; it holds until the next read anyway
    task automatic rreg(input logic [7:0] a, output logic [7:0] d);
        cyc(1);
        addr = a;
        rd = 1'b1;
        cyc(1);
        rd = 1'b0;
        cyc(1);
        d = rdata;
    endtask
    task automatic chk(input logic [PIN_W-1:0] s, input logic [PIN_W-1:0] e);
        cmp_count++;
        if (s !== e) begin
            errors++;
            $display("FAIL %0t ns: saw %h, wanted %h", $time, s, e);
        end
    endtask
    task automatic end_of_test;
        if (errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // A hang counts against the run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            $display("FAIL %0t ns: run did not finish", $time);
            end_of_test();
        end
    end
    initial begin
        cyc(2);
        chk(pad_oe, '0);
        chk(pu, PIN_PRESENT);
        nrst = 1'b1;
        for (int i = 0; i < 6; i++) begin
            rreg(ga[i], v);
            chk(v, ge[i]);
        end
        for (int i = 0; i < 9; i++) begin
            wreg(ra[i], rw[i]);
            rreg(ra[i], v);
            chk(v, re[i]);
        end
        // Port 0 driven, read back through the pins
        wreg(ADDR_PORT0_DATA, 8'ha5);
        wreg(ADDR_PORT0_DIR, 8'h00);
        cyc(8);
        chk(pad_oe[7:0], 8'hff);
        chk(pad_out[7:0], 8'ha5);
        chk(pst, 24'h00db00);
        rreg(ADDR_PORT0_DATA, v);
        chk(v, 8'ha5);
        // Port 3 split between pull-up and pull-down
        pull_select[23:16] = 8'h0f;
        cyc(8);
        chk(pdn[23:16], 8'hf0);
        rreg(ADDR_PORT3_DATA, v);
        chk(v, 8'h0f);
        chk(ext_int, 2'b11);
        chk(irq[23:16], 8'h03);
        // Closed input gate hides the pins
        wreg(ADDR_PORT3_GATE, 8'h00);
        cyc(8);
        rreg(ADDR_PORT3_DATA, v);
        chk(v, 8'h00);
        chk(ext_int, 2'b00);
        wreg(ADDR_PORT3_GATE, 8'hff);
        // Read gives the pins, not the latch, with holes at bits 2 and 5
        pull_enable[15:8] = 8'h00;
        ext_en[15:8] = 8'hdb;
        ext_val[15:8] = 8'hdb;
        wreg(ADDR_PORT1_DATA, 8'h00);
        cyc(8);
        rreg(ADDR_PORT1_DATA, v);
        chk(v, 8'hdb);
        chk(irq[15:8], 8'hdb);
        // Power-down: vector moves, pin levels stop, external lines stay
        pd = 1'b1;
        cyc(3);
        chk(vec, VEC_POWERDOWN);
        chk(irq, '0);
        chk(ext_int, 2'b11);
        pd = 1'b0;
        cyc(3);
        chk(vec, VEC_NORMAL);
        // Reset in mid-run returns every pin to a pulled-up input
        nrst = 1'b0;
        cyc(2);
        chk(pad_oe, '0);
        chk(pu, PIN_PRESENT);
        nrst = 1'b1;
        rreg(ADDR_PORT0_DIR, v);
        chk(v, 8'hff);
        end_of_test();
    end
endmodule
bind tpg_gpio tpg_gpio_checker u_tpg_gpio_checker (
    .CLK, .NRST, .SFR_ADDR, .SFR_WR, .SFR_RD, .SFR_WDATA, .SFR_RDATA,
    .PAD_OUT, .PAD_OE, .PAD_PULL_UP, .PAD_PULL_DOWN, .PAD_STRENGTH,
    .POWER_DOWN, .PIN_IRQ_LEVEL, .EXT_INT_LEVEL, .IRQ_VECTOR);
`default_nettype wire
